/* File: src/line_test_pattern_loopback.sv */
// per-channel test pattern, loopback and inband code logic
// assumes line clocks and data arrive as asynchronous pins and a
// register master on sys_clk that never waits
//
// Summary of operation
// - clock select high, field 00: send zeros
// - QRSS 2^20-1 in T1, PRBS 2^15-1 E1
// - field 10 sends pseudo-random pattern MSB first
// - pattern sent true or inverted by control
// - sync set at <=6 errors per 64 bits
// - sync changes captured, edge select, enable interrupt
// - error select 00 counts PRBS errors, 16 bit
// - analog loop: transmit into receive, line still driven
// - digital loop: transmit into decoder, line still driven
// - internal patterns override transmit during local loops
// - remote loop sends recovered data back to line
// - field 11 repeats programmed loop code
// - detect loop codes despite occasional bit errors
// - transmit code 5 to 8 bits long
// - code stops with clock select 0, field 00
// - activate and deactivate codes with own lengths
// - activate status after 30/40 ms presence
// - deactivate status after 30/40 ms presence
// - code status edge select; capture clears on read
// - auto loop: activate 5.1 s establishes loop
// - auto loop: deactivate 5.1 s releases loop
// - clearing auto enable releases loop at once
// - field 01 sends continuous ones
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "line_test_consts.svh"

module line_test_pattern_loopback #(
    parameter int unsigned CODE_E1_CYCLES = `CODE_E1_MS * `CLK_KHZ,
    parameter int unsigned CODE_T1_CYCLES = `CODE_T1_MS * `CLK_KHZ,
    parameter int unsigned AUTO_CYCLES = `AUTO_LOOP_MS * `CLK_KHZ
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input line_test_pkg::reg_req_t regReq,
    output logic [7:0] regRdata,
    input wire logic transmitClock,
    input wire logic masterClock,
    input wire logic txSysData,
    input wire logic rxRecClock,
    input wire logic rxRecData,
    output logic lineTxData,
    output logic rxOutData,
    output logic rxOutStrobe,
    output logic analogLoopActive,
    output logic digitalLoopActive,
    output logic irq
);
    // 0 tclk, 1 mclk, 2 tx data, 3 rx clock, 4 rx data
    localparam int NPIN = 5;

    logic [1:0] rstSync;
    logic rst_n;
    logic [NPIN-1:0] pin1, pin2, pin3, pinStable, pinPrev;
    logic [7:0] pattSel_reg, loopCtl_reg, codeLen_reg, txCode_reg;
    logic [7:0] actCode_reg, deactCode_reg, errCtl_reg, intEn_reg;
    logic [7:0] edgeSel_reg, regRdata_next;
    logic [19:0] prbsGen_reg, chk_reg;
    logic [63:0] errWin_reg;
    logic [6:0] errCnt_reg, errCnt_next;
    logic [15:0] errTotal_reg;
    logic [2:0] codeIdx_reg;
    logic [7:0] hist_reg;
    logic [5:0] blockCnt_reg;
    logic [3:0] actHits_reg, deactHits_reg;
    logic actPresent_reg, deactPresent_reg;
    logic [31:0] actTime_reg, deactTime_reg, codeCycles;
    logic syncStat_reg, actStat_reg, deactStat_reg, autoLoop_reg;
    logic [2:0] statPrev_reg, capture_reg, events;
    logic lineTx_reg, rxOut_reg, rxStrobe_reg, loopTick_reg, irq_reg;
    logic tclkTick, mclkTick, rxClkTick, txTick, rxTick, rxVal;
    logic remoteEff, localLoop, e1Mode, invert, patClk, prbsErr;
    logic prbsTxBit, codeTxBit, chkBit, txBit, readCapture;
    line_test_pkg::pattern_t patt;

    function automatic logic prbsBit(input logic [19:0] s,
                                     input logic e1);
        // zero limiting forces a one after 14 quiet stages
        if (e1)
            prbsBit = s[14] ^ s[13];
        else
            prbsBit = (s[19] ^ s[16]) | (s[13:0] == 14'h0000);
    endfunction

    function automatic logic [3:0] codeLen(input logic [1:0] sel);
        codeLen = {2'b00, sel} + 4'h5;
    endfunction

    // low L bits of the pattern, oldest bit in the highest position
    function automatic logic codeMatch(input logic [7:0] h,
                                       input logic [7:0] p,
                                       input logic [1:0] sel);
        logic [7:0] mask;
        mask = 8'hff >> (4'h8 - codeLen(sel));
        codeMatch = ((h ^ p) & mask) == 8'h00;
    endfunction

    function automatic logic edgeEvt(input logic old, input logic cur,
                                     input logic anyChange);
        edgeEvt = anyChange ? (old != cur) : (!old && cur);
    endfunction

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            rstSync <= 2'b00;
        else
            rstSync <= {rstSync[0], 1'b1};
    end
    assign rst_n = rstSync[1];

    // a pin level counts only once stages two and three agree
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin1 <= '0;
            pin2 <= '0;
            pin3 <= '0;
            pinStable <= '0;
            pinPrev <= '0;
        end else begin
            pin1 <= {rxRecData, rxRecClock, txSysData, masterClock,
                     transmitClock};
            pin2 <= pin1;
            pin3 <= pin2;
            pinStable <= (pin2 & pin3) | (pinStable & (pin2 | pin3));
            pinPrev <= pinStable;
        end
    end

    assign tclkTick = pinStable[0] && !pinPrev[0];
    assign mclkTick = pinStable[1] && !pinPrev[1];
    assign rxClkTick = pinStable[3] && !pinPrev[3];
    assign patt = line_test_pkg::pattern_t'(pattSel_reg[`PSC_PATT_LSB +: 2]);
    assign patClk = pattSel_reg[`PSC_CLK_BIT];
    assign invert = pattSel_reg[`PSC_INV_BIT];
    assign e1Mode = pattSel_reg[`PSC_E1_BIT];
    assign localLoop = loopCtl_reg[`LBC_ANALOG_BIT]
                       | loopCtl_reg[`LBC_DIGITAL_BIT];
    assign remoteEff = loopCtl_reg[`LBC_REMOTE_BIT] | autoLoop_reg;

    // normal data always runs on tclk; internal patterns on either
    always_comb begin
        if (remoteEff)
            txTick = rxClkTick;
        else if (patt == line_test_pkg::PAT_NORMAL && !patClk)
            txTick = tclkTick;
        else
            txTick = patClk ? mclkTick : tclkTick;
    end

    assign prbsTxBit = prbsBit(prbsGen_reg, e1Mode) ^ invert;
    assign codeTxBit = txCode_reg[codeIdx_reg];

    always_comb begin
        if (remoteEff)
            txBit = pinStable[4];
        else
            case (patt)
                line_test_pkg::PAT_ONES: txBit = 1'b1;
                line_test_pkg::PAT_PRBS: txBit = prbsTxBit;
                line_test_pkg::PAT_CODE: txBit = codeTxBit;
                default: txBit = patClk ? 1'b0 : pinStable[2];
            endcase
    end

    // the line keeps its pattern in local loops too
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lineTx_reg <= 1'b0;
            loopTick_reg <= 1'b0;
        end else begin
            loopTick_reg <= txTick;
            if (txTick)
                lineTx_reg <= txBit;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            prbsGen_reg <= `PRBS_SEED;
        else if (txTick && !remoteEff && patt == line_test_pkg::PAT_PRBS)
            prbsGen_reg <= {prbsGen_reg[18:0],
                            prbsBit(prbsGen_reg, e1Mode)};
    end

    // code index restarts whenever code mode is left
    always_ff @(posedge sys_clk or negedge rst_n) begin
        logic [3:0] last;
        last = codeLen(codeLen_reg[`CLC_TX_LSB +: 2]) - 4'h1;
        if (!rst_n)
            codeIdx_reg <= 3'h4;
        else if (patt != line_test_pkg::PAT_CODE || remoteEff)
            codeIdx_reg <= last[2:0];
        else if (txTick)
            codeIdx_reg <= (codeIdx_reg == 3'h0) ? last[2:0]
                           : codeIdx_reg - 3'h1;
    end

    // receive path: looped transmit stream or recovered line data
    assign rxTick = localLoop ? loopTick_reg : rxClkTick;
    assign rxVal = localLoop ? lineTx_reg : pinStable[4];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxOut_reg <= 1'b0;
            rxStrobe_reg <= 1'b0;
        end else begin
            rxStrobe_reg <= rxTick;
            if (rxTick)
                rxOut_reg <= rxVal;
        end
    end

    // self-synchronising checker fed with received bits
    assign chkBit = rxVal ^ invert;
    assign prbsErr = rxTick && (chkBit != prbsBit(chk_reg, e1Mode));
    assign errCnt_next = errCnt_reg + {6'h00, prbsErr}
                         - {6'h00, errWin_reg[63]};

    // window starts full of errors so sync must be earned
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            chk_reg <= `PRBS_SEED;
            errWin_reg <= '1;
            errCnt_reg <= `WIN_RESET_COUNT;
            syncStat_reg <= 1'b0;
        end else if (rxTick) begin
            chk_reg <= {chk_reg[18:0], chkBit};
            errWin_reg <= {errWin_reg[62:0], prbsErr};
            errCnt_reg <= errCnt_next;
            syncStat_reg <= errCnt_next <= `WIN_ERR_LIMIT;
        end
    end

    // saturates rather than wraps; rewriting the select clears it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            errTotal_reg <= 16'h0000;
        else if (regReq.wr && regReq.addr == `ADDR_ERROR_COUNT_CTL)
            errTotal_reg <= 16'h0000;
        else if (prbsErr && errTotal_reg != 16'hffff
                 && errCtl_reg[`ECC_SEL_LSB +: 2] == `ECC_SEL_PRBS)
            errTotal_reg <= errTotal_reg + 16'h0001;
    end

    // a code counts as present when enough aligned copies land in a
    // 64-bit block, so a stray bit error costs only a few copies
    always_ff @(posedge sys_clk or negedge rst_n) begin
        logic actHit, deactHit;
        actHit = codeMatch({hist_reg[6:0], rxVal}, actCode_reg,
                           codeLen_reg[`CLC_ACT_LSB +: 2]);
        deactHit = codeMatch({hist_reg[6:0], rxVal}, deactCode_reg,
                             codeLen_reg[`CLC_DEACT_LSB +: 2]);
        if (!rst_n) begin
            hist_reg <= 8'h00;
            blockCnt_reg <= 6'h00;
            actHits_reg <= 4'h0;
            deactHits_reg <= 4'h0;
            actPresent_reg <= 1'b0;
            deactPresent_reg <= 1'b0;
        end else if (rxTick) begin
            hist_reg <= {hist_reg[6:0], rxVal};
            blockCnt_reg <= blockCnt_reg + 6'h01;
            if (blockCnt_reg == 6'h3f) begin
                actPresent_reg <= actHits_reg >= `CODE_MIN_HITS;
                deactPresent_reg <= deactHits_reg >= `CODE_MIN_HITS;
                actHits_reg <= 4'h0;
                deactHits_reg <= 4'h0;
            end else begin
                if (actHit && actHits_reg != 4'hf)
                    actHits_reg <= actHits_reg + 4'h1;
                if (deactHit && deactHits_reg != 4'hf)
                    deactHits_reg <= deactHits_reg + 4'h1;
            end
        end
    end

    assign codeCycles = e1Mode ? CODE_E1_CYCLES : CODE_T1_CYCLES;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            actTime_reg <= 32'h0;
            deactTime_reg <= 32'h0;
        end else begin
            if (!actPresent_reg)
                actTime_reg <= 32'h0;
            else if (actTime_reg <= AUTO_CYCLES)
                actTime_reg <= actTime_reg + 32'h1;
            if (!deactPresent_reg)
                deactTime_reg <= 32'h0;
            else if (deactTime_reg <= AUTO_CYCLES)
                deactTime_reg <= deactTime_reg + 32'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            actStat_reg <= 1'b0;
            deactStat_reg <= 1'b0;
        end else begin
            actStat_reg <= actTime_reg > codeCycles;
            deactStat_reg <= deactTime_reg > codeCycles;
        end
    end

    // release has priority, so a deactivate never loses to activate
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            autoLoop_reg <= 1'b0;
        else if (!loopCtl_reg[`LBC_AUTO_BIT])
            autoLoop_reg <= 1'b0;
        else if (deactTime_reg > AUTO_CYCLES)
            autoLoop_reg <= 1'b0;
        else if (actTime_reg > AUTO_CYCLES)
            autoLoop_reg <= 1'b1;
    end

    assign events = {
        edgeEvt(statPrev_reg[2], deactStat_reg, edgeSel_reg[2]),
        edgeEvt(statPrev_reg[1], actStat_reg, edgeSel_reg[1]),
        edgeEvt(statPrev_reg[0], syncStat_reg, edgeSel_reg[0])
    };
    assign readCapture = regReq.rd && regReq.addr == `ADDR_INT_CAPTURE;

    // a new event in the read cycle survives the clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            statPrev_reg <= 3'h0;
            capture_reg <= 3'h0;
            irq_reg <= 1'b0;
        end else begin
            statPrev_reg <= {deactStat_reg, actStat_reg, syncStat_reg};
            capture_reg <= (readCapture ? 3'h0 : capture_reg)
                           | events;
            irq_reg <= |(capture_reg & intEn_reg[2:0]);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pattSel_reg <= `REG_RESET;
            loopCtl_reg <= `REG_RESET;
            codeLen_reg <= `REG_RESET;
            txCode_reg <= `REG_RESET;
            actCode_reg <= `REG_RESET;
            deactCode_reg <= `REG_RESET;
            errCtl_reg <= `REG_RESET;
            intEn_reg <= `REG_RESET;
            edgeSel_reg <= `REG_RESET;
        end else if (regReq.wr) begin
            case (regReq.addr)
                `ADDR_PATTERN_SELECT: pattSel_reg <= regReq.wdata;
                `ADDR_LOOPBACK: loopCtl_reg <= regReq.wdata;
                `ADDR_CODE_LENGTH: codeLen_reg <= regReq.wdata;
                `ADDR_TX_LOOP_CODE: txCode_reg <= regReq.wdata;
                `ADDR_RX_ACTIVATE: actCode_reg <= regReq.wdata;
                `ADDR_RX_DEACTIVATE: deactCode_reg <= regReq.wdata;
                `ADDR_ERROR_COUNT_CTL: errCtl_reg <= regReq.wdata;
                `ADDR_INT_ENABLE: intEn_reg <= regReq.wdata;
                `ADDR_INT_EDGE_SELECT: edgeSel_reg <= regReq.wdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        case (regReq.addr)
            `ADDR_PATTERN_SELECT: regRdata_next = pattSel_reg;
            `ADDR_LOOPBACK: regRdata_next = loopCtl_reg;
            `ADDR_CODE_LENGTH: regRdata_next = codeLen_reg;
            `ADDR_TX_LOOP_CODE: regRdata_next = txCode_reg;
            `ADDR_RX_ACTIVATE: regRdata_next = actCode_reg;
            `ADDR_RX_DEACTIVATE: regRdata_next = deactCode_reg;
            `ADDR_ERROR_COUNT_CTL: regRdata_next = errCtl_reg;
            `ADDR_INT_ENABLE: regRdata_next = intEn_reg;
            `ADDR_INT_EDGE_SELECT: regRdata_next = edgeSel_reg;
            `ADDR_STATUS_0: regRdata_next = {5'h00, deactStat_reg,
                                             actStat_reg, syncStat_reg};
            `ADDR_STATUS_1: regRdata_next = {7'h00, remoteEff};
            `ADDR_INT_CAPTURE: regRdata_next = {5'h00, capture_reg};
            `ADDR_ERR_COUNT_LO: regRdata_next = errTotal_reg[7:0];
            `ADDR_ERR_COUNT_HI: regRdata_next = errTotal_reg[15:8];
            default: regRdata_next = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            regRdata <= 8'h00;
        else
            regRdata <= regReq.rd ? regRdata_next : 8'h00;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            analogLoopActive <= 1'b0;
            digitalLoopActive <= 1'b0;
        end else begin
            analogLoopActive <= loopCtl_reg[`LBC_ANALOG_BIT];
            digitalLoopActive <= loopCtl_reg[`LBC_DIGITAL_BIT];
        end
    end

    assign lineTxData = lineTx_reg;
    assign rxOutData = rxOut_reg;
    assign rxOutStrobe = rxStrobe_reg;
    assign irq = irq_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_zeros;
        txTick && !remoteEff && patClk && patt == line_test_pkg::PAT_NORMAL
        |=> !lineTxData;
    endproperty
    a_zeros: assert property (p_zeros)
        else $error("zeros not sent");

    property p_ones;
        txTick && !remoteEff && patt == line_test_pkg::PAT_ONES
        |=> lineTxData;
    endproperty
    a_ones: assert property (p_ones)
        else $error("ones not sent");

    property p_prbs;
        txTick && !remoteEff && patt == line_test_pkg::PAT_PRBS
        |=> lineTxData == $past(prbsTxBit);
    endproperty
    a_prbs: assert property (p_prbs)
        else $error("prbs bit wrong");

    property p_sync;
        syncStat_reg == (errCnt_reg <= `WIN_ERR_LIMIT);
    endproperty
    a_sync: assert property (p_sync)
        else $error("sync status disagrees with error count");

    property p_capture;
        $rose(syncStat_reg) |=> capture_reg[`EVT_SYNC_BIT];
    endproperty
    a_capture: assert property (p_capture)
        else $error("sync rise not captured");

    property p_remote;
        remoteEff && rxClkTick |=> lineTxData == $past(pinStable[4]);
    endproperty
    a_remote: assert property (p_remote)
        else $error("remote loop data wrong");

    property p_loopout;
        localLoop && rxTick |=> rxOutStrobe && rxOutData == $past(lineTxData);
    endproperty
    a_loopout: assert property (p_loopout)
        else $error("looped bit not on receive output");

    property p_code;
        txTick && !remoteEff && patt == line_test_pkg::PAT_CODE
        |=> lineTxData == $past(codeTxBit);
    endproperty
    a_code: assert property (p_code)
        else $error("loop code bit wrong");

    property p_act;
        actTime_reg > codeCycles |=> actStat_reg;
    endproperty
    a_act: assert property (p_act)
        else $error("activate status late");

    property p_release;
        !loopCtl_reg[`LBC_AUTO_BIT] |=> !autoLoop_reg;
    endproperty
    a_release: assert property (p_release)
        else $error("auto loop not released");

    property p_rdclear;
        readCapture && events == 3'h0 |=> capture_reg == 3'h0;
    endproperty
    a_rdclear: assert property (p_rdclear)
        else $error("capture not cleared by read");

    c_sync: cover property ($rose(syncStat_reg));
    c_auto: cover property ($rose(autoLoop_reg));
    c_irq: cover property ($rose(irq_reg));
endmodule

/* File: src/line_test_consts.svh */
// offsets, field positions, reset values and timing figures of the
// per-channel maintenance block; included by the block and its bench
`ifndef LINE_TEST_CONSTS_SVH
`define LINE_TEST_CONSTS_SVH

`define ADDR_PATTERN_SELECT 8'h0a
`define ADDR_LOOPBACK 8'h0b
`define ADDR_CODE_LENGTH 8'h0c
`define ADDR_TX_LOOP_CODE 8'h0d
`define ADDR_RX_ACTIVATE 8'h0e
`define ADDR_RX_DEACTIVATE 8'h0f
`define ADDR_ERROR_COUNT_CTL 8'h10
`define ADDR_INT_ENABLE 8'h11
`define ADDR_INT_EDGE_SELECT 8'h13
`define ADDR_STATUS_0 8'h14
`define ADDR_STATUS_1 8'h15
`define ADDR_INT_CAPTURE 8'h16
`define ADDR_ERR_COUNT_LO 8'h18
`define ADDR_ERR_COUNT_HI 8'h19

`define PSC_PATT_LSB 0
`define PSC_CLK_BIT 2
`define PSC_INV_BIT 3
`define PSC_E1_BIT 4
`define LBC_ANALOG_BIT 0
`define LBC_DIGITAL_BIT 1
`define LBC_REMOTE_BIT 2
`define LBC_AUTO_BIT 3
`define CLC_TX_LSB 0
`define CLC_ACT_LSB 2
`define CLC_DEACT_LSB 4
`define ECC_SEL_LSB 0
`define ECC_SEL_PRBS 2'h0
`define EVT_SYNC_BIT 0
`define EVT_ACT_BIT 1
`define EVT_DEACT_BIT 2

`define REG_RESET 8'h00
`define PRBS_SEED 20'hfffff
`define WIN_ERR_LIMIT 7'h06
`define WIN_RESET_COUNT 7'h40
`define CODE_MIN_HITS 4'h6

`define CLK_KHZ 125000
`define CODE_E1_MS 30
`define CODE_T1_MS 40
`define AUTO_LOOP_MS 5100

`endif

/* File: src/line_test_pkg.sv */
// types shared by the maintenance block and its bench
// assumes nothing beyond a SystemVerilog compiler
package line_test_pkg;
    typedef enum logic [1:0] {
        PAT_NORMAL = 2'b00,
        PAT_ONES = 2'b01,
        PAT_PRBS = 2'b10,
        PAT_CODE = 2'b11
    } pattern_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage

/* File: verif/line_far_end.sv */
// remote terminal model: sends random traffic or a repeated loop code
// assumes sys_clk as timebase; line clock half period is 4 sys_clk
`timescale 1ns/1ps
module line_far_end (
    input wire logic sys_clk,
    input wire logic mode,
    input wire logic [7:0] code,
    input wire logic [1:0] len,
    output logic rxRecClock,
    output logic rxRecData
);
    int cnt = 0;
    int idx = 0;
    initial begin
        rxRecClock = 1'b0;
        rxRecData = 1'b0;
    end
    // a line runs without pause, so the recovered clock never stops
    always @(posedge sys_clk) begin
        cnt <= (cnt == 3) ? 0 : cnt + 1;
        if (cnt == 3) begin
            rxRecClock <= ~rxRecClock;
            if (rxRecClock) begin
                idx = (idx == 0) ? int'(len) + 4 : idx - 1;
                rxRecData <= mode ? code[idx] : 1'($urandom);
            end
        end
    end
endmodule

/* File: verif/line_test_pattern_loopback_test.sv */
// self-checking bench of the maintenance block with a far-end model
// assumes shortened code and auto-loop times via parameters
`timescale 1ns/1ps
`include "line_test_consts.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module line_test_pattern_loopback_test;
    logic sys_clk = 0, rstn = 0, transmitClock = 0, masterClock = 0;
    logic txSysData = 0, lineTxData, rxOutData, rxOutStrobe, irq;
    logic rxRecClock, rxRecData, fMode = 0, aLoop, dLoop;
    logic [1:0] fLen = 0;
    logic [7:0] fCode = 0, regRdata, d, c;
    logic [63:0] h;
    line_test_pkg::reg_req_t regReq = '0;
    int error_cnt = 0, checked = 0, cyc = 0;
    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    always begin
        repeat (6) @(posedge sys_clk);
        transmitClock <= ~transmitClock;
        txSysData <= 1'($urandom);
    end
    always begin
        repeat (5) @(posedge sys_clk);
        masterClock <= ~masterClock;
    end
    line_test_pattern_loopback #(.CODE_E1_CYCLES(50), .CODE_T1_CYCLES(60),
        .AUTO_CYCLES(400)) line_test_pattern_loopback_i (.sys_clk(sys_clk),
        .rstn(rstn), .regReq(regReq), .regRdata(regRdata),
        .transmitClock(transmitClock), .masterClock(masterClock),
        .txSysData(txSysData), .rxRecClock(rxRecClock),
        .rxRecData(rxRecData), .lineTxData(lineTxData),
        .rxOutData(rxOutData), .rxOutStrobe(rxOutStrobe),
        .analogLoopActive(aLoop), .digitalLoopActive(dLoop), .irq(irq));
    line_far_end line_far_end_i (.sys_clk(sys_clk), .mode(fMode),
        .code(fCode), .len(fLen), .rxRecClock(rxRecClock),
        .rxRecData(rxRecData));
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        regReq <= '{a, v, 1'b1, 1'b0};
        @(posedge sys_clk);
        regReq.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        regReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk);
        regReq.rd <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic wt(input logic [7:0] a, input int b, input logic v);
        for (int i = 0; i < 2000; i++) begin
            rd(a);
            if (d[b] === v) break;
        end
    endtask
    // line bits sampled late in each master-clock period, newest in h[0]
    task automatic bits(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge masterClock);
            repeat (8) @(posedge sys_clk);
            h = {h[62:0], lineTxData};
        end
    endtask
    function automatic int bad(logic [63:0] x, logic e1, logic inv);
        logic [63:0] b;
        int n;
        b = inv ? ~x : x;
        n = 0;
        for (int p = 0; p < 44; p++)
            if (b[p] !== (e1 ? b[p+15] ^ b[p+14]
                : (b[p+20] ^ b[p+17]) | (b[p+1+:14] == 14'h0000))) n++;
        return n;
    endfunction
    function automatic logic isrot(logic [7:0] x, logic [7:0] k, int L);
        logic [15:0] m, dd;
        m = (16'h0001 << L) - 16'h0001;
        dd = ((16'(k) & m) << L) | (16'(k) & m);
        isrot = 1'b0;
        for (int r = 0; r < L; r++)
            if (((dd >> r) & m) == (16'(x) & m)) isrot = 1'b1;
    endfunction
    task automatic tally_and_finish();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hc33a));
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int a = 8'h0a; a <= 8'h17; a++) begin
            rd(8'(a));
            `CHK(d, `REG_RESET)
        end
        // select 00 counts far-end noise from reset; park it to read zero
        wr(`ADDR_ERROR_COUNT_CTL, 8'h01);
        for (int a = 8'h18; a <= 8'h19; a++) begin
            rd(8'(a));
            `CHK(d, 8'h00)
        end
        for (int a = 8'h0a; a <= 8'h13; a++) begin
            c = $urandom;
            wr(8'(a), c);
            rd(8'(a));
            `CHK(d, (a == 8'h12) ? 8'h00 : c)
        end
        wr(`ADDR_PATTERN_SELECT, 8'h00);
        wr(`ADDR_LOOPBACK, 8'h00);
        wr(`ADDR_ERROR_COUNT_CTL, 8'h00);
        $display("test registers done");
        wr(`ADDR_PATTERN_SELECT, 8'h04);
        bits(20);
        `CHK(h[15:0], 16'h0000)
        wr(`ADDR_PATTERN_SELECT, 8'h05);
        bits(20);
        `CHK(h[15:0], 16'hffff)
        for (int l = 0; l < 4; l++) begin
            c = $urandom;
            wr(`ADDR_CODE_LENGTH, 8'(l));
            wr(`ADDR_TX_LOOP_CODE, c);
            wr(`ADDR_PATTERN_SELECT, 8'h07);
            bits(28);
            `CHK(h[15:0], h[l+5+:16])
            `CHK(isrot(h[7:0], c, l + 5), 1'b1)
        end
        $display("test fixed patterns done");
        // 8-bit codes almost never show up in pattern or noise
        wr(`ADDR_CODE_LENGTH, 8'h3c);
        wr(`ADDR_INT_EDGE_SELECT, 8'h00);
        wr(`ADDR_INT_ENABLE, 8'h01);
        wr(`ADDR_LOOPBACK, 8'h02);
        wr(`ADDR_PATTERN_SELECT, 8'h16);
        wt(`ADDR_STATUS_0, 0, 1'b1);
        `CHK(d[0], 1'b1)
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'b1)
        `CHK({aLoop, dLoop}, 2'b01)
        rd(`ADDR_INT_CAPTURE);
        `CHK(d[0], 1'b1)
        rd(`ADDR_INT_CAPTURE);
        `CHK(d, 8'h00)
        `CHK(irq, 1'b0)
        for (int m = 0; m < 4; m++) begin
            wr(`ADDR_PATTERN_SELECT, {3'b000, m[0], m[1], 3'b110});
            bits(64);
            `CHK(bad(h, m[0], m[1]), 0)
        end
        wr(`ADDR_PATTERN_SELECT, 8'h16);
        // mode switches above drop and regain sync; flush those captures
        wt(`ADDR_STATUS_0, 0, 1'b1);
        rd(`ADDR_INT_CAPTURE);
        wr(`ADDR_LOOPBACK, 8'h00);
        wt(`ADDR_STATUS_0, 0, 1'b0);
        `CHK(d[0], 1'b0)
        rd(`ADDR_INT_CAPTURE);
        `CHK(d[0], 1'b0)
        rd(`ADDR_ERR_COUNT_LO);
        c = d;
        rd(`ADDR_ERR_COUNT_HI);
        `CHK((c | d) != 8'h00, 1'b1)
        $display("test prbs done");
        wr(`ADDR_PATTERN_SELECT, 8'h10);
        wr(`ADDR_LOOPBACK, 8'h08);
        wr(`ADDR_CODE_LENGTH, 8'h0c);
        wr(`ADDR_RX_ACTIVATE, 8'h8e);
        wr(`ADDR_RX_DEACTIVATE, 8'h13);
        wr(`ADDR_INT_EDGE_SELECT, 8'h06);
        fMode <= 1'b1;
        fCode <= 8'h8e;
        fLen <= 2'd3;
        wt(`ADDR_STATUS_0, 1, 1'b1);
        `CHK(d[1], 1'b1)
        wt(`ADDR_STATUS_1, 0, 1'b1);
        `CHK(d[0], 1'b1)
        fMode <= 1'b0;
        repeat (1500) @(posedge sys_clk);
        rd(`ADDR_STATUS_1);
        `CHK(d[0], 1'b1)
        rd(`ADDR_INT_CAPTURE);
        `CHK(d[1], 1'b1)
        fMode <= 1'b1;
        fCode <= 8'h13;
        fLen <= 2'd0;
        wt(`ADDR_STATUS_1, 0, 1'b0);
        `CHK(d[0], 1'b0)
        rd(`ADDR_STATUS_0);
        `CHK(d[2], 1'b1)
        fCode <= 8'h8e;
        fLen <= 2'd3;
        wt(`ADDR_STATUS_1, 0, 1'b1);
        wr(`ADDR_LOOPBACK, 8'h00);
        rd(`ADDR_STATUS_1);
        `CHK(d[0], 1'b0)
        $display("test loop codes done");
        tally_and_finish();
    end
endmodule
